// *** hdl/pcmsp_alaw.sv ***
// Combinational companding encoder and decoder between 13-bit linear and 8-bit codes.
`timescale 1ns/1ps
`include "pcmsp_cfg.svh"
module pcmsp_alaw
  import pcmsp_pkg::*;
(
  input  wire pcmsp_lin_t  i_enc_lin,
  output pcmsp_alaw_t      o_enc_code,
  input  wire pcmsp_alaw_t i_dec_code,
  output pcmsp_lin_t       o_dec_lin
);

  // Encoder: sign, segment of the leading one, four mantissa bits, then even-bit inversion.
  always_comb
  begin
    logic [12:0] neg;
    logic [11:0] mag;
    logic [2:0]  seg;
    logic [3:0]  mant;
    neg  = 13'(-i_enc_lin);
    mag  = 12'h000;
    seg  = 3'h0;
    mant = 4'h0;
    // The most negative sample has no positive twin, so it clips to full scale.
    if (!i_enc_lin[12])
    begin
      mag = i_enc_lin[11:0];
    end
    else if (i_enc_lin == 13'sh1000)
    begin
      mag = 12'hFFF;
    end
    else
    begin
      mag = neg[11:0];
    end
    for (int b = 5; b < 12; b++)
    begin
      if (mag[b])
      begin
        seg = 3'(b - 4);
      end
    end
    // Segment zero is uniform; higher segments keep the four bits under the leading one.
    if (seg == 3'h0)
    begin
      mant = mag[4:1];
    end
    else
    begin
      mant = 4'(mag >> seg);
    end
    o_enc_code = {~i_enc_lin[12], seg, mant} ^ `PCMSP_ALAW_XOR;
  end

  // Decoder: rebuild the magnitude at the middle of its step and apply the sign.
  always_comb
  begin
    logic [7:0]  c;
    logic [11:0] dmag;
    c    = i_dec_code ^ `PCMSP_ALAW_XOR;
    dmag = 12'h000;
    if (c[6:4] == 3'h0)
    begin
      dmag = {7'h00, c[3:0], 1'b1};
    end
    else
    begin
      dmag = 12'({6'h00, 1'b1, c[3:0], 1'b1} << (c[6:4] - 3'h1));
    end
    o_dec_lin = c[7] ? pcmsp_lin_t'({1'b0, dmag}) : pcmsp_lin_t'(-{1'b0, dmag});
  end

endmodule

// *** hdl/pcmsp_cfg.svh ***
// Constants of the PCM serial port: word sizes, frame length, timing counts and codec values.
`ifndef PCMSP_CFG_SVH
`define PCMSP_CFG_SVH

// Master bit clock cycles from one frame sync to the next.
`define PCMSP_FRAME_CYCLES 9'd256
// Saturation value of the frame length counter.
`define PCMSP_FRAME_CNT_MAX 9'h1FF
// Transmit word length in linear coding.
`define PCMSP_LIN_TX_BITS 5'd13
// Receive word length in linear coding: sample bits plus gain code bits.
`define PCMSP_LIN_RX_BITS 5'd16
// Word length in companded coding, both directions.
`define PCMSP_CMP_BITS 5'd8
// System clock period in picoseconds.
`define PCMSP_CLK_PERIOD_PS 4000
// Time without any bit clock edge after which the clock counts as lost.
`define PCMSP_LOSS_TIME_NS 2000
// Longest wait, rounded down to whole system clock cycles.
`define PCMSP_LOSS_CYCLES ((`PCMSP_LOSS_TIME_NS * 1000) / `PCMSP_CLK_PERIOD_PS)
// Least reset pulse the host applies, and its count rounded up.
`define PCMSP_RESET_MIN_NS 500
`define PCMSP_RESET_MIN_CYCLES ((`PCMSP_RESET_MIN_NS * 1000 + `PCMSP_CLK_PERIOD_PS - 1) / `PCMSP_CLK_PERIOD_PS)
// Even-bit inversion pattern of the companded code.
`define PCMSP_ALAW_XOR 8'h55
// Receive gain codes and their Q8 linear factors, 3 dB apart.
`define PCMSP_GAIN_0DB 3'h1
`define PCMSP_COEF_P3 10'h16A
`define PCMSP_COEF_0 10'h100
`define PCMSP_COEF_M3 10'h0B5
`define PCMSP_COEF_M6 10'h080
`define PCMSP_COEF_M9 10'h05B
`define PCMSP_COEF_M12 10'h040
`define PCMSP_COEF_M15 10'h02E
`define PCMSP_COEF_M18 10'h020
// Limits of a 13-bit two's-complement sample.
`define PCMSP_LIN_MAX 16'sh0FFF
`define PCMSP_LIN_MIN -16'sh1000

`endif

// *** hdl/pcmsp_pkg.sv ***
// Types shared by the PCM serial port modules.
package pcmsp_pkg;
  // Transmit word sequencer states.
  typedef enum logic [1:0] {TXS_IDLE, TXS_ARMED, TXS_SHIFT} pcmsp_tx_state_t;
  // A 13-bit two's-complement linear sample.
  typedef logic signed [12:0] pcmsp_lin_t;
  // An 8-bit companded code.
  typedef logic [7:0] pcmsp_alaw_t;
  // A 3-bit receive gain code.
  typedef logic [2:0] pcmsp_gain_t;
endpackage

// *** hdl/pcmsp_serial_port.sv ***
// PCM serial data port with law selection, gain, mutes and automatic power-down.
// Functional notes
// R1: Host makes each frame 256 bit clocks.
// R2: Frame sync sampled on bit clock fall.
// R3: Receive bit captured on bit clock fall.
// R4: Transmit bits driven on bit clock rises.
// R5: Output released on fall ending last bit.
// R6: Bit one is MSB, last is LSB.
// R7: Host holds reset at least 500 ns.
// R8: Clock loss powers down, output high impedance.
// R9: Power-down waits for word in flight.
// R10: Law select low linear, high companded.
// R11: Linear words are 13-bit two's complement.
// R12: Companded words use the 8-bit A-law code.
// R13: Transmit mute attenuates sample before encoding.
// R14: Receive word 8 bits or 13 plus gain.
// R15: Linear gain code in 3 dB steps.
// R16: Receive mute silences receive output.
// R17: One transmit word per frame, else idle.
// R18: Host pulses sync one bit clock per frame.
`timescale 1ns/1ps
`include "pcmsp_cfg.svh"
module pcmsp_serial_port
  import pcmsp_pkg::*;
#(
  parameter int LOSS_CYCLES = `PCMSP_LOSS_CYCLES
)
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_bit_clk,
  input  wire logic       i_frame_sync_pulse,
  input  wire logic       i_serial_rx_data_in,
  input  wire logic       i_law_select,
  input  wire logic       i_transmit_mute,
  input  wire logic       i_receive_mute,
  input  wire logic       i_pwr_down_req,
  input  wire pcmsp_lin_t i_tx_sample,
  output logic            o_serial_tx_data_out,
  output logic            o_serial_tx_data_out_oe,
  output logic            o_tx_sample_take,
  output pcmsp_lin_t      o_rx_sample,
  output pcmsp_gain_t     o_rx_gain_code,
  output logic            o_rx_valid,
  output logic            o_power_down,
  output logic            o_frame_err
);

  logic            bclk_q_r;     // Bit clock level one system cycle ago.
  logic            bclk_rise;    // Bit clock rose this cycle.
  logic            bclk_fall;    // Bit clock fell this cycle.
  logic            sync_fall;    // Frame sync seen high on a bit clock fall.
  logic [15:0]     loss_cnt_r;   // Cycles since the last bit clock edge.
  logic            clock_lost_r; // Bit clock has stopped.
  pcmsp_tx_state_t tx_state_r;   // Transmit sequencer state.
  logic [12:0]     tx_shift_r;   // Transmit word, MSB at the top.
  logic [4:0]      tx_cnt_r;     // Transmit bits driven so far.
  logic            tx_law_r;     // Law of the word being sent.
  logic [4:0]      tx_len;       // Length of the word being sent.
  logic            tx_load;      // A new word is taken this cycle.
  pcmsp_lin_t      tx_lin;       // Transmit sample after the mute.
  pcmsp_alaw_t     tx_code;      // Companded transmit code.
  logic [12:0]     tx_word;      // Word as it enters the shifter.
  logic            rx_active_r;  // Receive word in progress.
  logic [4:0]      rx_cnt_r;     // Receive bits captured so far.
  logic [15:0]     rx_shift_r;   // Receive shifter, last bit at the bottom.
  logic            rx_law_r;     // Law of the word being received.
  logic            rx_done_r;    // Receive word complete, one-cycle pulse.
  logic [4:0]      rx_len;       // Length of the word being received.
  pcmsp_lin_t      rx_dec_lin;   // Decoded companded sample.
  pcmsp_lin_t      rx_lin;       // Receive sample before gain.
  pcmsp_gain_t     rx_gain;      // Gain code that applies to it.
  pcmsp_lin_t      rx_out;       // Receive sample after gain and clipping.
  logic [8:0]      frame_cnt_r;  // Bit clock falls since the last sync.
  logic            frame_seen_r; // At least one sync has been seen.

  // The bit clock is a synchronous input, so its edges are found by comparing with last cycle.
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      bclk_q_r <= 1'b0;
    end
    else
    begin
      bclk_q_r <= i_bit_clk;
    end
  end

  assign bclk_rise = i_bit_clk & ~bclk_q_r;
  assign bclk_fall = ~i_bit_clk & bclk_q_r;
  assign sync_fall = bclk_fall & i_frame_sync_pulse; // R2

  // Watchdog on the bit clock; any edge restarts it, a long silence marks the clock lost.
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      loss_cnt_r   <= 16'h0000;
      clock_lost_r <= 1'b0;
    end
    else if (bclk_rise || bclk_fall)
    begin
      loss_cnt_r   <= 16'h0000;
      clock_lost_r <= 1'b0;
    end
    else if (loss_cnt_r == 16'(LOSS_CYCLES - 1))
    begin
      clock_lost_r <= 1'b1; // R8
    end
    else
    begin
      loss_cnt_r <= loss_cnt_r + 16'h0001;
    end
  end

  // Power-down: immediate on clock loss, otherwise only once no transmit word is in flight.
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_power_down <= 1'b0;
    end
    else if (clock_lost_r)
    begin
      o_power_down <= 1'b1; // R8
    end
    else if (i_pwr_down_req)
    begin
      if (tx_state_r == TXS_IDLE)
      begin
        o_power_down <= 1'b1; // R9
      end
    end
    else
    begin
      o_power_down <= 1'b0;
    end
  end

  // Mute forces silence: 80 dB below full scale is under one step of a 13-bit sample.
  assign tx_lin  = i_transmit_mute ? 13'sh0000 : i_tx_sample; // R13
  assign tx_word = i_law_select ? {tx_code, 5'h00} : tx_lin; // R10 R11 R12
  assign tx_len  = tx_law_r ? `PCMSP_CMP_BITS : `PCMSP_LIN_TX_BITS; // R10
  // A pending power-down request keeps a new word from starting.
  assign tx_load = sync_fall && !o_power_down && !i_pwr_down_req && (tx_state_r == TXS_IDLE);

  // Shared companding unit: encodes the transmit sample, decodes the received code.
  pcmsp_alaw u_alaw
  (
    .i_enc_lin  (tx_lin),
    .o_enc_code (tx_code),
    .i_dec_code (rx_shift_r[7:0]),
    .o_dec_lin  (rx_dec_lin)
  );

  // Transmit sequencer: arm on sync, drive bits on rises, release on the fall ending the last bit.
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      tx_state_r              <= TXS_IDLE;
      tx_shift_r              <= 13'h0000;
      tx_cnt_r                <= 5'h00;
      tx_law_r                <= 1'b0;
      o_serial_tx_data_out    <= 1'b0;
      o_serial_tx_data_out_oe <= 1'b0;
      o_tx_sample_take        <= 1'b0;
    end
    else
    begin
      o_tx_sample_take <= 1'b0;
      if (clock_lost_r)
      begin
        // A stopped clock can never finish the word, so the pin is released at once.
        tx_state_r              <= TXS_IDLE; // R8
        o_serial_tx_data_out    <= 1'b0;
        o_serial_tx_data_out_oe <= 1'b0;
      end
      else
      begin
        case (tx_state_r)
          TXS_IDLE:
          begin
            // One word per frame, taken at the sync.
            if (tx_load)
            begin
              tx_shift_r       <= tx_word; // R17
              tx_law_r         <= i_law_select;
              o_tx_sample_take <= 1'b1;
              tx_state_r       <= TXS_ARMED;
            end
          end
          TXS_ARMED:
          begin
            // First bit, the MSB, on the rise that opens bit one.
            if (bclk_rise)
            begin
              o_serial_tx_data_out    <= tx_shift_r[12]; // R4 R6
              o_serial_tx_data_out_oe <= 1'b1;
              tx_shift_r              <= {tx_shift_r[11:0], 1'b0};
              tx_cnt_r                <= 5'h01;
              tx_state_r              <= TXS_SHIFT;
            end
          end
          TXS_SHIFT:
          begin
            if (bclk_fall && (tx_cnt_r == tx_len))
            begin
              o_serial_tx_data_out    <= 1'b0; // R5
              o_serial_tx_data_out_oe <= 1'b0;
              tx_state_r              <= TXS_IDLE;
            end
            else if (bclk_rise && (tx_cnt_r != tx_len))
            begin
              o_serial_tx_data_out <= tx_shift_r[12]; // R4 R6
              tx_shift_r           <= {tx_shift_r[11:0], 1'b0};
              tx_cnt_r             <= tx_cnt_r + 5'h01;
            end
          end
          default:
          begin
            tx_state_r <= TXS_IDLE;
          end
        endcase
      end
    end
  end

  assign rx_len = rx_law_r ? `PCMSP_CMP_BITS : `PCMSP_LIN_RX_BITS; // R14

  // Receive shifter: the fall after the sync captures bit one, MSB first.
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      rx_active_r <= 1'b0;
      rx_cnt_r    <= 5'h00;
      rx_shift_r  <= 16'h0000;
      rx_law_r    <= 1'b0;
      rx_done_r   <= 1'b0;
    end
    else
    begin
      rx_done_r <= 1'b0;
      if (clock_lost_r)
      begin
        rx_active_r <= 1'b0;
      end
      else if (bclk_fall)
      begin
        if (rx_active_r)
        begin
          rx_shift_r <= {rx_shift_r[14:0], i_serial_rx_data_in}; // R3 R6
          rx_cnt_r   <= rx_cnt_r + 5'h01;
          if (rx_cnt_r == rx_len - 5'h01)
          begin
            rx_active_r <= 1'b0; // R14
            rx_done_r   <= 1'b1;
          end
        end
        else if (i_frame_sync_pulse && !o_power_down)
        begin
          rx_active_r <= 1'b1; // R2
          rx_cnt_r    <= 5'h00;
          rx_law_r    <= i_law_select; // R10
        end
      end
    end
  end

  // Split the received word and scale it by the gain code; companded words get 0 dB.
  always_comb
  begin
    logic signed [23:0] prod;
    logic signed [15:0] scaled;
    logic [9:0]         coef;
    prod    = 24'sh000000;
    scaled  = 16'sh0000;
    coef    = 10'h000;
    rx_lin  = rx_law_r ? rx_dec_lin : pcmsp_lin_t'(rx_shift_r[15:3]); // R11 R12
    rx_gain = rx_law_r ? `PCMSP_GAIN_0DB : rx_shift_r[2:0]; // R15
    case (rx_gain)
      3'h0:    coef = `PCMSP_COEF_P3;
      3'h1:    coef = `PCMSP_COEF_0;
      3'h2:    coef = `PCMSP_COEF_M3;
      3'h3:    coef = `PCMSP_COEF_M6;
      3'h4:    coef = `PCMSP_COEF_M9;
      3'h5:    coef = `PCMSP_COEF_M12;
      3'h6:    coef = `PCMSP_COEF_M15;
      default: coef = `PCMSP_COEF_M18;
    endcase
    prod   = 24'(rx_lin) * 24'($signed({1'b0, coef})); // R15
    scaled = prod[23:8];
    // Only the +3 dB step can overflow; it clips rather than wraps.
    if (scaled > `PCMSP_LIN_MAX)
    begin
      rx_out = 13'sh0FFF;
    end
    else if (scaled < `PCMSP_LIN_MIN)
    begin
      rx_out = 13'sh1000;
    end
    else
    begin
      rx_out = pcmsp_lin_t'(scaled[12:0]);
    end
  end

  // Receive output register: one valid pulse per received word.
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_rx_sample    <= 13'sh0000;
      o_rx_gain_code <= 3'h0;
      o_rx_valid     <= 1'b0;
    end
    else
    begin
      o_rx_valid <= rx_done_r;
      if (rx_done_r)
      begin
        o_rx_sample    <= i_receive_mute ? 13'sh0000 : rx_out; // R16
        o_rx_gain_code <= rx_gain;
      end
    end
  end

  // Frame length monitor: flags any sync interval other than 256 bit clocks.
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      frame_cnt_r  <= 9'h000;
      frame_seen_r <= 1'b0;
      o_frame_err  <= 1'b0;
    end
    else if (sync_fall)
    begin
      frame_cnt_r  <= 9'h001;
      frame_seen_r <= 1'b1;
      if (frame_seen_r)
      begin
        o_frame_err <= (frame_cnt_r != `PCMSP_FRAME_CYCLES); // R1
      end
    end
    else if (bclk_fall && (frame_cnt_r != `PCMSP_FRAME_CNT_MAX))
    begin
      frame_cnt_r <= frame_cnt_r + 9'h001;
    end
  end

  // The first bit appears with the enable, one cycle after the opening rise.
  a_tx_first_bit: assert property (@(posedge i_clk) disable iff (!i_nrst) // R4
    (tx_state_r == TXS_ARMED && bclk_rise && !clock_lost_r)
    |=> (o_serial_tx_data_out_oe && o_serial_tx_data_out == $past(tx_shift_r[12])))
    else $error("first transmit bit not driven on the opening rise");

  a_tx_release: assert property (@(posedge i_clk) disable iff (!i_nrst) // R5
    (tx_state_r == TXS_SHIFT && bclk_fall && tx_cnt_r == tx_len) |=> !o_serial_tx_data_out_oe)
    else $error("transmit output not released after the last bit");

  a_tx_oe_word: assert property (@(posedge i_clk) disable iff (!i_nrst) // R17
    o_serial_tx_data_out_oe |-> (tx_state_r == TXS_SHIFT && tx_cnt_r >= 5'h01 && tx_cnt_r <= tx_len))
    else $error("transmit output driven outside a word");

  a_loss_hiz: assert property (@(posedge i_clk) disable iff (!i_nrst) // R8
    clock_lost_r |=> (!o_serial_tx_data_out_oe && o_power_down))
    else $error("clock loss did not power down and release the output");

  a_pd_defer: assert property (@(posedge i_clk) disable iff (!i_nrst) // R9
    $rose(o_power_down) |-> ($past(clock_lost_r) || $past(tx_state_r) == TXS_IDLE))
    else $error("power-down cut a transmit word short");

  a_tx_load_word: assert property (@(posedge i_clk) disable iff (!i_nrst) // R10
    (tx_load && !clock_lost_r && !i_law_select && !i_transmit_mute) |=> tx_shift_r == $past(i_tx_sample))
    else $error("linear transmit word differs from the sample");

  a_tx_mute_zero: assert property (@(posedge i_clk) disable iff (!i_nrst) // R13
    (tx_load && !clock_lost_r && !i_law_select && i_transmit_mute) |=> tx_shift_r == 13'h0000)
    else $error("muted transmit word not silent");

  a_rx_capture: assert property (@(posedge i_clk) disable iff (!i_nrst) // R3
    (bclk_fall && rx_active_r && !clock_lost_r) |=> rx_shift_r[0] == $past(i_serial_rx_data_in))
    else $error("receive bit not captured on the falling edge");

  a_rx_mute_out: assert property (@(posedge i_clk) disable iff (!i_nrst) // R16
    (rx_done_r && i_receive_mute) |=> (o_rx_valid && o_rx_sample == 13'sh0000))
    else $error("muted receive sample not silent");

  a_rx_cmp_gain: assert property (@(posedge i_clk) disable iff (!i_nrst) // R15
    (rx_done_r && rx_law_r) |=> o_rx_gain_code == `PCMSP_GAIN_0DB)
    else $error("companded receive gain not fixed at 0 dB");

  a_arm_on_sync: assert property (@(posedge i_clk) disable iff (!i_nrst) // R2
    (tx_state_r == TXS_ARMED && $past(tx_state_r) == TXS_IDLE) |-> $past(sync_fall))
    else $error("transmit word armed without a sampled sync");

endmodule

// *** tb/pcmsp_host_model.sv ***
// Host model: makes the bit clock, frame sync and receive bits, and captures the transmit word.
`timescale 1ns/1ps
module pcmsp_host_model
#(
  parameter int HALF = 4
)
(
  input  wire logic        i_clk,
  input  wire logic        i_run,
  input  wire logic [15:0] i_rx_word,
  input  wire logic [4:0]  i_rx_len,
  input  wire logic        i_tx_data,
  input  wire logic        i_tx_oe,
  output logic             o_bit_clk,
  output logic             o_sync,
  output logic             o_rx_data,
  output logic [7:0]       o_slot,
  output logic [15:0]      o_tx_word,
  output logic [4:0]       o_tx_cnt
);
  int ph; // System cycles spent in the current bit clock half.

  // Start values, so that no line is unknown before the first edge.
  initial
  begin
    ph = 0;
    {o_bit_clk, o_sync, o_rx_data, o_tx_word, o_tx_cnt} = '0;
    o_slot = 8'hFF;
  end

  // All changes land on the falling system clock edge, away from the device's sampling edge.
  always @(negedge i_clk)
  begin
    if (!i_run)
    begin
      o_bit_clk <= 1'b0; // A stopped clock stands still.
      o_sync <= 1'b0;
      o_rx_data <= ~o_rx_data; // The receive line shows no stale value.
    end
    else if (ph == HALF - 1)
    begin
      ph <= 0;
      o_bit_clk <= ~o_bit_clk;
      if (!o_bit_clk)
      begin
        // Rising bit clock opens the next of 256 slots.
        o_slot <= o_slot + 8'h01;
        o_sync <= (o_slot == 8'hFF);
        o_rx_data <= (o_slot < {3'h0, i_rx_len}) ? i_rx_word[i_rx_len - 5'h01 - o_slot[4:0]] : ~o_rx_data;
        if (o_slot == 8'hFF)
          o_tx_cnt <= 5'h00;
      end
      else if (i_tx_oe)
      begin
        // Falling bit clock: the host takes each driven transmit bit.
        o_tx_word <= {o_tx_word[14:0], i_tx_data};
        o_tx_cnt <= o_tx_cnt + 5'h01;
      end
    end
    else
      ph <= ph + 1;
  end
endmodule

// *** tb/pcmsp_serial_port_tb.sv ***
// Self-checking testbench of the PCM serial port facing the host model.
`timescale 1ns/1ps
`include "pcmsp_cfg.svh"
module pcmsp_serial_port_tb
  import pcmsp_pkg::*;
;
  localparam int LOSS = 20; // Short clock-loss wait for simulation.
  logic        clk, nrst, law, tmute, rmute, pdreq, run;
  logic        bclk, sync, rxd, txd, txoe, take, rx_valid, pdown, ferr;
  pcmsp_lin_t  tx_sample, rx_sample, rx_s;
  pcmsp_gain_t rx_gain, rx_g;
  logic [15:0] rx_word, tx_word;
  logic [4:0]  rx_len, tx_cnt;
  logic [7:0]  slot, pd_at;
  int          err_total, n_checks, nvalid, ntake, cycles;
  int coef [8] = '{`PCMSP_COEF_P3, `PCMSP_COEF_0, `PCMSP_COEF_M3, `PCMSP_COEF_M6,
                   `PCMSP_COEF_M9, `PCMSP_COEF_M12, `PCMSP_COEF_M15, `PCMSP_COEF_M18};

  pcmsp_serial_port #(.LOSS_CYCLES(LOSS)) pcmsp_serial_port_i (
    .i_clk(clk), .i_nrst(nrst), .i_bit_clk(bclk), .i_frame_sync_pulse(sync),
    .i_serial_rx_data_in(rxd), .i_law_select(law), .i_transmit_mute(tmute),
    .i_receive_mute(rmute), .i_pwr_down_req(pdreq), .i_tx_sample(tx_sample),
    .o_serial_tx_data_out(txd), .o_serial_tx_data_out_oe(txoe), .o_tx_sample_take(take),
    .o_rx_sample(rx_sample), .o_rx_gain_code(rx_gain), .o_rx_valid(rx_valid),
    .o_power_down(pdown), .o_frame_err(ferr));

  pcmsp_host_model #(.HALF(4)) pcmsp_host_model_i (
    .i_clk(clk), .i_run(run), .i_rx_word(rx_word), .i_rx_len(rx_len), .i_tx_data(txd),
    .i_tx_oe(txoe), .o_bit_clk(bclk), .o_sync(sync), .o_rx_data(rxd), .o_slot(slot),
    .o_tx_word(tx_word), .o_tx_cnt(tx_cnt));

  // Free-running 250 MHz system clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts pulses, keeps the last received word, and cuts a hang short; sampled mid-cycle where outputs are settled.
  always @(negedge clk)
  begin
    cycles++;
    if (rx_valid === 1'b1)
    begin
      nvalid++;
      rx_s = rx_sample;
      rx_g = rx_gain;
    end
    if (take === 1'b1)
      ntake++;
    if (cycles > 90000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected receive sample after the gain stage, floored and clipped.
  function automatic logic [15:0] gained(input pcmsp_lin_t v, input int g);
    int p;
    p = (int'(v) * coef[g]) >>> 8;
    if (p > `PCMSP_LIN_MAX)
      p = `PCMSP_LIN_MAX;
    if (p < `PCMSP_LIN_MIN)
      p = `PCMSP_LIN_MIN;
    return 16'(p);
  endfunction

  // Runs one frame: loads the words, waits for the sync slot and for both words to finish.
  task automatic frame(input pcmsp_lin_t s, input logic [15:0] w, input logic [4:0] n);
    @(negedge clk);
    tx_sample = s;
    rx_word = w;
    rx_len = n;
    wait (slot == 8'h00);
    nvalid = 0;
    ntake = 0;
    if (pd_at != 8'h00)
    begin
      wait (slot == pd_at);
      pdreq = 1'b1;
    end
    wait (slot == 8'h28);
  endtask

  // Checks what one frame carried in both directions; a negative valid count skips the receive side.
  task automatic expect_frame(input logic [15:0] tx_exp, input logic [4:0] tx_n, input int valids,
                              input logic [15:0] rx_exp, input pcmsp_gain_t g_exp);
    logic [15:0] m;
    m = (16'h0001 << tx_n) - 16'h0001;
    chk("tx bit count", 16'(tx_n), 16'(tx_cnt));
    chk("tx word", tx_exp & m, tx_word & m);
    chk("take pulses", 16'(tx_n != 5'h00), 16'(ntake));
    if (valids >= 0)
    begin
      chk("rx valids", 16'(valids), 16'(nvalid));
      chk("rx sample", rx_exp, 16'(rx_s));
      chk("rx gain", 16'(g_exp), 16'(rx_g));
    end
  endtask

  // Main sequence.
  initial
  begin
    {nrst, law, tmute, rmute, pdreq, pd_at, tx_sample, rx_word} = '0;
    {err_total, n_checks, nvalid, ntake, cycles} = '0;
    run = 1'b1;
    rx_len = 5'h10;
    repeat (128) @(negedge clk);
    chk("oe in reset", 16'h0000, 16'(txoe));
    chk("power down in reset", 16'h0000, 16'(pdown));
    nrst = 1'b1;
    // First sync only starts the frame timer.
    frame(13'h0000, 16'h0000, 5'h10);
    // Every receive gain code, each frame with its own transmit sample.
    for (int g = 0; g < 8; g++)
    begin
      frame(13'(13'h0A5A + g), {13'h03E8, 3'(g)}, 5'h10);
      expect_frame(16'(13'h0A5A + g), 5'h0D, 1, gained(13'h03E8, g), 3'(g));
      chk("frame error", 16'h0000, 16'(ferr));
    end
    // Extremes: clipping, floor of a negative product, most negative transmit code.
    frame(13'h1000, {13'h0FFF, 3'h0}, 5'h10);
    expect_frame(16'h1000, 5'h0D, 1, 16'h0FFF, 3'h0);
    frame(13'h0FFF, {13'h1C18, 3'h0}, 5'h10);
    expect_frame(16'h0FFF, 5'h0D, 1, gained(13'h1C18, 0), 3'h0);
    // Both mutes.
    tmute = 1'b1;
    rmute = 1'b1;
    frame(13'h0ABC, {13'h03E8, 3'h1}, 5'h10);
    expect_frame(16'h0000, 5'h0D, 1, 16'h0000, 3'h1);
    tmute = 1'b0;
    rmute = 1'b0;
    // Companded coding: eight-bit words both ways, gain fixed at 0 dB.
    law = 1'b1;
    frame(13'h0000, 16'h00AA, 5'h08);
    expect_frame(16'h00D5, 5'h08, 1, 16'h0FC0, `PCMSP_GAIN_0DB);
    frame(13'h0064, 16'h00D5, 5'h08);
    expect_frame(16'h00FC, 5'h08, 1, 16'h0001, `PCMSP_GAIN_0DB);
    frame(13'h0FFF, 16'h00FC, 5'h08);
    expect_frame(16'h00AA, 5'h08, 1, 16'h0066, `PCMSP_GAIN_0DB);
    law = 1'b0;
    // Power-down request in mid-word: the word finishes first.
    pd_at = 8'h05;
    frame(13'h1555, {13'h03E8, 3'h1}, 5'h10);
    pd_at = 8'h00;
    expect_frame(16'h1555, 5'h0D, -1, 16'h0000, 3'h0);
    chk("power down", 16'h0001, 16'(pdown));
    frame(13'h0123, {13'h03E8, 3'h1}, 5'h10);
    expect_frame(16'h0000, 5'h00, -1, 16'h0000, 3'h0);
    pdreq = 1'b0;
    frame(13'h0321, {13'h0100, 3'h1}, 5'h10);
    expect_frame(16'h0321, 5'h0D, 1, gained(13'h0100, 1), 3'h1);
    chk("power up", 16'h0000, 16'(pdown));
    // Clock loss in mid-word.
    wait (slot == 8'h03);
    run = 1'b0;
    repeat (LOSS / 2) @(negedge clk);
    chk("early power down", 16'h0000, 16'(pdown));
    repeat (LOSS) @(negedge clk);
    chk("lost clock power down", 16'h0001, 16'(pdown));
    chk("lost clock oe", 16'h0000, 16'(txoe));
    run = 1'b1;
    frame(13'h0000, {13'h0000, 3'h1}, 5'h10);
    frame(13'h0777, {13'h0200, 3'h2}, 5'h10);
    expect_frame(16'h0777, 5'h0D, 1, gained(13'h0200, 2), 3'h2);
    report_and_stop();
  end
endmodule
